// ---- rtl/cism_pkg.sv ----
// package: register map, field positions and reset values of the interrupt block
package cism_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 16;
  // register offsets (word addresses)
  localparam logic [11:0] ADDR_FLAGS_ONE  = 12'h730;
  localparam logic [11:0] ADDR_FLAGS_TWO  = 12'h731;
  localparam logic [11:0] ADDR_LEVELS     = 12'h732;
  localparam logic [11:0] ADDR_GATE_ONE   = 12'h738;
  localparam logic [11:0] ADDR_GATE_TWO   = 12'h739;
  localparam logic [11:0] ADDR_LINE_GATE  = 12'h740;
  localparam logic [11:0] ADDR_FILTER_CFG = 12'h748;
  // implemented bits per register and edge masks of the second flags
  localparam logic [15:0] FLAGS_ONE_BITS  = 16'h07a1;
  localparam logic [15:0] FLAGS_TWO_BITS  = 16'hdbe3;
  localparam logic [15:0] BOTH_EDGE_TWO   = 16'h81e3;
  localparam logic [15:0] RISE_EDGE_TWO   = 16'h5a00;
  // reset values and writable bits
  localparam logic [15:0] GATE_ONE_RST    = 16'h07ff;
  localparam logic [15:0] GATE_TWO_RST    = 16'hdbe3;
  localparam logic [15:0] LINE_GATE_RST   = 16'h0000;
  localparam logic [15:0] FILTER_CFG_RST  = 16'h003f;
  localparam logic [15:0] GATE_ONE_BITS   = 16'h07ff;
  localparam logic [15:0] FILTER_CFG_BITS = 16'h003f;
  // field positions
  localparam int          BIT_WARN        = 15;
  localparam int          BIT_STOP        = 0;
  localparam int          BIT_LINE_GATE   = 0;
  localparam int          BIT_WARN_FILT   = 5;
  localparam int          BIT_STOP_FILT   = 0;
  // thermal filter time and its cycle count at 40 MHz
  localparam int          CLK_HZ          = 40000000;
  localparam int          FILTER_US       = 100;
  localparam int          FILTER_CYC      = FILTER_US * (CLK_HZ / 1000000);
endpackage

// ---- rtl/cism_top.sv ----
// interrupt status, raw level, mask and output logic of the codec
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module cism_top
  import cism_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // first group sources
  input  wire logic              pin1_level,
  input  wire logic              pin8_level,
  input  wire logic              pin9_level,
  input  wire logic              pin10_level,
  input  wire logic              pin11_level,
  input  wire logic              plug_level,
  // second group sources
  input  wire logic              overheat_warn_in,
  input  wire logic              offset_servo_done_level,
  input  wire logic              core_queue_error_level,
  input  wire logic              port2_dynamics_detect_level,
  input  wire logic              port1_dynamics_detect_level,
  input  wire logic              conv2_lock_level,
  input  wire logic              conv1_lock_level,
  input  wire logic              loop2_lock_level,
  input  wire logic              loop1_lock_level,
  input  wire logic              mic_detect_level,
  input  wire logic              overheat_stop_in,
  // interrupt output, active high
  output logic                   irq
);

  logic [15:0] gate_one_q;
  logic [15:0] gate_two_q;
  logic [15:0] line_gate_q;
  logic [15:0] filter_cfg_q;
  logic [15:0] flags_one_q;
  logic [15:0] flags_two_q;
  logic [15:0] src_one;
  logic [15:0] src_two;
  logic [15:0] prev_one_q;
  logic [15:0] prev_two_q;
  logic [15:0] set_one;
  logic [15:0] set_two;
  logic [15:0] clr_one;
  logic [15:0] clr_two;
  logic        primed_q;
  logic        warn_filt_q;
  logic        stop_filt_q;
  logic        overheat_warn_level;
  logic        overheat_stop_level;
  logic [DATA_W-1:0] rdata_d;

  // thermal inputs: a change is accepted once stable for the filter time
  logic [1:0]  therm_raw;
  logic [1:0]  therm_filt;
  logic [1:0]  therm_en;
  assign therm_raw = {overheat_warn_in, overheat_stop_in};
  assign therm_en  = {filter_cfg_q[BIT_WARN_FILT], filter_cfg_q[BIT_STOP_FILT]};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_therm
      logic [31:0] cnt_q;
      logic        stable_q;
      // counts how long the input has differed from the accepted level
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_q <= 32'h0000_0000;
        end else if (therm_raw[g] == stable_q) begin
          cnt_q <= 32'h0000_0000;
        end else if (cnt_q >= 32'(FILTER_CYCLES - 1)) begin
          cnt_q <= 32'h0000_0000;
        end else begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
      end

      // short glitches never reach the flags, at the cost of filter latency
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stable_q <= 1'b0;
        end else if (therm_raw[g] != stable_q && cnt_q >= 32'(FILTER_CYCLES - 1)) begin
          stable_q <= therm_raw[g];
        end
      end

      // filter off passes the input straight through
      assign therm_filt[g] = therm_en[g] ? stable_q : therm_raw[g];
    end
  endgenerate

  assign warn_filt_q         = therm_filt[1];
  assign stop_filt_q         = therm_filt[0];
  assign overheat_warn_level = warn_filt_q;
  assign overheat_stop_level = stop_filt_q;

  // live levels, laid out at the flag positions
  always_comb begin
    src_one     = 16'h0000;
    src_one[10] = pin11_level;
    src_one[9]  = pin10_level;
    src_one[8]  = pin9_level;
    src_one[7]  = pin8_level;
    src_one[5]  = plug_level;
    src_one[0]  = pin1_level;
    src_two           = 16'h0000;
    src_two[BIT_WARN] = overheat_warn_level;
    src_two[14]       = offset_servo_done_level;
    src_two[12]       = core_queue_error_level;
    src_two[11]       = port2_dynamics_detect_level;
    src_two[9]        = port1_dynamics_detect_level;
    src_two[8]        = conv2_lock_level;
    src_two[7]        = conv1_lock_level;
    src_two[6]        = loop2_lock_level;
    src_two[5]        = loop1_lock_level;
    src_two[1]        = mic_detect_level;
    src_two[BIT_STOP] = overheat_stop_level;
  end

  // history of levels; first cycle after reset only primes it, so no false edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_one_q <= 16'h0000;
      prev_two_q <= 16'h0000;
      primed_q   <= 1'b0;
    end else begin
      prev_one_q <= src_one;
      prev_two_q <= src_two;
      primed_q   <= 1'b1;
    end
  end

  // rising and falling events per position
  logic [15:0] rise_one;
  logic [15:0] fall_one;
  logic [15:0] rise_two;
  logic [15:0] fall_two;

  assign rise_one = src_one & ~prev_one_q;
  assign fall_one = prev_one_q & ~src_one;
  assign rise_two = src_two & ~prev_two_q;
  assign fall_two = prev_two_q & ~src_two;

  // edge kind of each position is fixed by the package masks
  genvar e;
  generate
    for (e = 0; e < 16; e++) begin : g_edge
      logic hit_one;
      logic hit_two;
      always_comb begin
        hit_one = 1'b0;
        hit_two = 1'b0;
        if (primed_q && FLAGS_ONE_BITS[e]) begin
          hit_one = rise_one[e] | fall_one[e];
        end
        if (primed_q && BOTH_EDGE_TWO[e]) begin
          hit_two = rise_two[e] | fall_two[e];
        end else if (primed_q && RISE_EDGE_TWO[e]) begin
          hit_two = rise_two[e];
        end
      end
      assign set_one[e] = hit_one;
      assign set_two[e] = hit_two;
    end
  endgenerate

  // write decodes, one per register; the raw level register has none
  logic wr_flags_one;
  logic wr_flags_two;
  logic wr_gate_one;
  logic wr_gate_two;
  logic wr_line_gate;
  logic wr_filter_cfg;

  assign wr_flags_one  = reg_write && (reg_addr == ADDR_FLAGS_ONE);
  assign wr_flags_two  = reg_write && (reg_addr == ADDR_FLAGS_TWO);
  assign wr_gate_one   = reg_write && (reg_addr == ADDR_GATE_ONE);
  assign wr_gate_two   = reg_write && (reg_addr == ADDR_GATE_TWO);
  assign wr_line_gate  = reg_write && (reg_addr == ADDR_LINE_GATE);
  assign wr_filter_cfg = reg_write && (reg_addr == ADDR_FILTER_CFG);

  // a written one clears, a written zero leaves the flag alone
  assign clr_one = wr_flags_one ? reg_wdata : 16'h0000;
  assign clr_two = wr_flags_two ? reg_wdata : 16'h0000;

  // one sticky cell per position; unimplemented positions stay zero
  genvar f;
  generate
    for (f = 0; f < 16; f++) begin : g_flag
      logic cell_one_q;
      logic cell_two_q;

      // set wins over a clear in the same cycle, so no event is lost
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cell_one_q <= 1'b0;
        end else if (!FLAGS_ONE_BITS[f]) begin
          cell_one_q <= 1'b0;
        end else if (set_one[f]) begin
          cell_one_q <= 1'b1;
        end else if (clr_one[f]) begin
          cell_one_q <= 1'b0;
        end
      end

      // masks are not looked at here: a masked source still flags
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cell_two_q <= 1'b0;
        end else if (!FLAGS_TWO_BITS[f]) begin
          cell_two_q <= 1'b0;
        end else if (set_two[f]) begin
          cell_two_q <= 1'b1;
        end else if (clr_two[f]) begin
          cell_two_q <= 1'b0;
        end
      end

      assign flags_one_q[f] = cell_one_q;
      assign flags_two_q[f] = cell_two_q;
    end
  endgenerate

  // first mask; reserved bits 11 to 15 read zero whatever software writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_one_q <= GATE_ONE_RST;
    end else if (wr_gate_one) begin
      gate_one_q <= reg_wdata & GATE_ONE_BITS;
    end
  end

  // second mask, at the flag positions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_two_q <= GATE_TWO_RST;
    end else if (wr_gate_two) begin
      gate_two_q <= reg_wdata & FLAGS_TWO_BITS;
    end
  end

  // global line gate, one bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_gate_q <= LINE_GATE_RST;
    end else if (wr_line_gate) begin
      line_gate_q <= reg_wdata & 16'h0001;
    end
  end

  // thermal filter enables, both on after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_cfg_q <= FILTER_CFG_RST;
    end else if (wr_filter_cfg) begin
      filter_cfg_q <= reg_wdata & FILTER_CFG_BITS;
    end
  end

  // flags allowed to reach the line
  logic [15:0] pend_one;
  logic [15:0] pend_two;
  logic        irq_d;

  assign pend_one = flags_one_q & ~gate_one_q & FLAGS_ONE_BITS;
  assign pend_two = flags_two_q & ~gate_two_q & FLAGS_TWO_BITS;
  assign irq_d    = ~line_gate_q[BIT_LINE_GATE] & (|pend_one | |pend_two);

  // registered so the line cannot glitch while flags clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // read data one cycle after the strobe, zero on unmapped addresses
  logic rd_flags_one;
  logic rd_flags_two;
  logic rd_levels;
  logic rd_gate_one;
  logic rd_gate_two;
  logic rd_line_gate;
  logic rd_filter_cfg;

  assign rd_flags_one  = (reg_addr == ADDR_FLAGS_ONE);
  assign rd_flags_two  = (reg_addr == ADDR_FLAGS_TWO);
  assign rd_levels     = (reg_addr == ADDR_LEVELS);
  assign rd_gate_one   = (reg_addr == ADDR_GATE_ONE);
  assign rd_gate_two   = (reg_addr == ADDR_GATE_TWO);
  assign rd_line_gate  = (reg_addr == ADDR_LINE_GATE);
  assign rd_filter_cfg = (reg_addr == ADDR_FILTER_CFG);

  // the mic source has no live bit, so position 1 reads zero there
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_flags_one) begin
      rdata_d = flags_one_q;
    end
    if (rd_flags_two) begin
      rdata_d = flags_two_q;
    end
    if (rd_levels) begin
      rdata_d = src_two & FLAGS_TWO_BITS & ~16'h0002;
    end
    if (rd_gate_one) begin
      rdata_d = gate_one_q;
    end
    if (rd_gate_two) begin
      rdata_d = gate_two_q;
    end
    if (rd_line_gate) begin
      rdata_d = line_gate_q;
    end
    if (rd_filter_cfg) begin
      rdata_d = filter_cfg_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ---- verif/cism_chk.sv ----
// checker: port assertions of the interrupt block
`timescale 1ns/10ps
module cism_chk
  import cism_pkg::*;
(
  // clock, reset, register port and line
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rd_of(logic [11:0] a);
    $past(reg_read) && $past(reg_addr) == a;
  endsequence
  a_line_forced: assert property (
    $past(reg_write) && $past(reg_addr) == ADDR_LINE_GATE && $past(reg_wdata[0]) |-> ##1 !irq)
    else $error("irq active with line gate set");
  a_drop_cause: assert property ($fell(irq) |-> $past(reg_write, 2))
    else $error("irq dropped without a write");
  a_gate_two_pos: assert property (rd_of(ADDR_GATE_TWO) |-> !(reg_rdata & ~FLAGS_TWO_BITS))
    else $error("gate two bit off flag position");
  a_gate_one_pos: assert property (rd_of(ADDR_GATE_ONE) |-> !(reg_rdata & ~GATE_ONE_BITS))
    else $error("gate one bit off position");
  a_filter_pos: assert property (rd_of(ADDR_FILTER_CFG) |-> reg_rdata[15:6] == 10'h000)
    else $error("filter config high bits set");
  a_flag_two_pos: assert property (rd_of(ADDR_FLAGS_TWO) |-> !(reg_rdata & ~FLAGS_TWO_BITS))
    else $error("flag two bit off position");
  a_flag_one_pos: assert property (rd_of(ADDR_FLAGS_ONE) |-> !(reg_rdata & ~FLAGS_ONE_BITS))
    else $error("flag one bit off position");
  a_level_pos: assert property (rd_of(ADDR_LEVELS) |-> !(reg_rdata & 16'h241e))
    else $error("level bit off position");
  c_raise: cover property ($rose(irq));
  c_drop: cover property ($fell(irq));
  c_level_read: cover property (rd_of(ADDR_LEVELS));
endmodule
bind cism_top cism_chk i_chk (.*);

// ---- verif/cism_host.sv ----
// host model: counts interrupt requests seen on its input
`timescale 1ns/10ps
module cism_host (
  // clock, reset, line and request count
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       irq,
  output logic      [7:0] irq_count_q
);
  logic irq_last_q;
  // a level line: one request per rise, however long it stays up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_last_q  <= 1'b0;
      irq_count_q <= 8'h00;
    end else begin
      irq_last_q  <= irq;
      irq_count_q <= irq_count_q + {7'h00, irq && !irq_last_q};
    end
  end
endmodule

// ---- verif/cism_top_tb.sv ----
// testbench: register, flag and interrupt line scenarios
`timescale 1ns/10ps
module cism_top_tb;
  import cism_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        irq;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] src = 16'h0000;
  logic [15:0] pins = 16'h0000;
  logic [7:0]  hcnt;
  int          fail_count = 0;
  int          checked = 0;
  int          two_b[9] = '{14, 12, 11, 9, 8, 7, 6, 5, 1};
  int          one_b[6] = '{10, 9, 8, 7, 5, 0};
  always #12.5 clk = ~clk;
  cism_top #(.FILTER_CYCLES(4)) i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(we), .reg_read(re), .reg_rdata(rdata), .irq(irq),
    .pin1_level(pins[0]), .pin8_level(pins[7]), .pin9_level(pins[8]), .pin10_level(pins[9]),
    .pin11_level(pins[10]), .plug_level(pins[5]), .overheat_warn_in(src[15]),
    .offset_servo_done_level(src[14]), .core_queue_error_level(src[12]),
    .port2_dynamics_detect_level(src[11]), .port1_dynamics_detect_level(src[9]),
    .conv2_lock_level(src[8]), .conv1_lock_level(src[7]), .loop2_lock_level(src[6]),
    .loop1_lock_level(src[5]), .mic_detect_level(src[1]), .overheat_stop_in(src[0]));
  cism_host i_host (.clk(clk), .reset_n(reset_n), .irq(irq), .irq_count_q(hcnt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic irq_is(input logic e);
    #1 chk({15'h0000, irq}, {15'h0000, e});
    @(posedge clk);
  endtask
  task automatic t_reset;
    rd(ADDR_GATE_ONE, 16'h07ff);
    rd(ADDR_GATE_TWO, 16'hdbe3);
    rd(ADDR_LINE_GATE, 16'h0000);
    rd(ADDR_FILTER_CFG, 16'h003f);
    wr(ADDR_LEVELS, 16'hffff);
    rd(ADDR_LEVELS, 16'h0000);
    irq_is(1'b0);
  endtask
  // each source toggled up then down; rise-only flags must ignore the fall
  task automatic t_edge(input logic [11:0] fa, input int b, input logic rise_only);
    logic [15:0] e;
    repeat (2) begin
      if (fa == ADDR_FLAGS_ONE) pins[b] <= ~pins[b];
      else src[b] <= ~src[b];
      repeat (3) @(posedge clk);
      e = (rise_only && !src[b]) ? 16'h0000 : 16'h0001 << b;
      irq_is(|e);
      rd(fa, e);
      if (fa == ADDR_FLAGS_TWO) rd(ADDR_LEVELS, src & 16'h5be0);
      wr(fa, 16'h0000);
      rd(fa, e);
      wr(fa, e);
      irq_is(1'b0);
    end
  endtask
  task automatic t_line;
    wr(ADDR_GATE_TWO, 16'hff7f);
    src[7] <= 1'b1;
    repeat (3) @(posedge clk);
    wr(ADDR_LINE_GATE, 16'h0001);
    irq_is(1'b0);
    wr(ADDR_LINE_GATE, 16'h0000);
    irq_is(1'b1);
    wr(ADDR_GATE_TWO, 16'hffff);
    irq_is(1'b0);
    wr(ADDR_FLAGS_TWO, 16'h0080);
    rd(ADDR_FLAGS_TWO, 16'h0000);
  endtask
  task automatic t_heat;
    src[15] <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_LEVELS, 16'h0080);
    repeat (8) @(posedge clk);
    rd(ADDR_LEVELS, 16'h8080);
    rd(ADDR_FLAGS_TWO, 16'h8000);
    wr(ADDR_FILTER_CFG, 16'h001e);
    rd(ADDR_FILTER_CFG, 16'h001e);
    src[0] <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_LEVELS, 16'h8081);
    rd(ADDR_FLAGS_TWO, 16'h8001);
    irq_is(1'b0);
  endtask
  task automatic close_out;
    $display("Counts: %0d mismatches, %0d checks", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset;
    wr(ADDR_GATE_TWO, 16'h8001);
    foreach (two_b[i]) t_edge(ADDR_FLAGS_TWO, two_b[i], i < 4);
    wr(ADDR_GATE_ONE, 16'h005e);
    foreach (one_b[i]) t_edge(ADDR_FLAGS_ONE, one_b[i], 1'b0);
    t_line;
    t_heat;
    chk({8'h00, hcnt}, 16'h001c);
    close_out;
  end
  initial begin
    #200000;
    fail_count++;
    close_out;
  end
endmodule
